// ===== hdl/wdl_loader.sv
`timescale 1ns/1ps

// Operation
// - capture whole host word into holding register
// - shift held word serially into channel register
// - only selected channel register receives shift
// - advance channel after word, until all loaded
// - update copies all staged weights at once
// - update returns multiplexer to first channel
// - 256 channels, eight-bit codes each
// - all host traffic passes through this block
module wdl_loader
(
    input  wire logic                      sys_clk_in,
    input  wire logic                      rstn_in,
    input  wire wdl_pkg::wdl_host_req_type host_req_in,
    output logic                           ready_out,
    output logic                           all_loaded_out,
    output logic [wdl_pkg::CH_W-1:0]       channel_out,
    output logic                           settling_out,
    output wdl_pkg::wdl_codes_type         dac_code_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wdl_pkg::wdl_state_type                state_reg;
    wdl_pkg::wdl_state_type                state_next;
    logic [wdl_pkg::WORD_W-1:0]            hold_reg;
    logic [wdl_pkg::BIT_CNT_W-1:0]         bit_cnt_reg;
    logic [wdl_pkg::CH_W-1:0]              chan_reg;
    logic [wdl_pkg::SETTLE_W-1:0]          settle_cnt_reg;
    logic [wdl_pkg::WORD_W-1:0]            stage_mem [wdl_pkg::CH_COUNT];
    logic                                  take_word;
    logic                                  take_update;
    logic                                  word_done;
    logic                                  chan_step;

    // wraps at the top channel; callers keep it from stepping past the last
    function automatic logic [wdl_pkg::CH_W-1:0] next_chan
    (
        input logic [wdl_pkg::CH_W-1:0] ch
    );
        return ch + wdl_pkg::CH_W'(1);
    endfunction : next_chan

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    // host traffic enters only through this port; update wins over load
    assign take_update = host_req_in.update && (state_reg != wdl_pkg::WDL_SHIFT);
    assign take_word   = host_req_in.load && !take_update
                         && (state_reg == wdl_pkg::WDL_IDLE);
    assign word_done   = (state_reg == wdl_pkg::WDL_SHIFT)
                         && (bit_cnt_reg == wdl_pkg::BIT_LAST);
    assign chan_step   = word_done && (chan_reg != wdl_pkg::LAST_CH);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            wdl_pkg::WDL_IDLE:
            begin
                if (take_word)
                begin
                    state_next = wdl_pkg::WDL_SHIFT;
                end
            end
            wdl_pkg::WDL_SHIFT:
            begin
                if (word_done)
                begin
                    if (chan_reg == wdl_pkg::LAST_CH)
                    begin
                        state_next = wdl_pkg::WDL_FULL;
                    end
                    else
                    begin
                        state_next = wdl_pkg::WDL_IDLE;
                    end
                end
            end
            wdl_pkg::WDL_FULL:
            begin
                if (take_update)
                begin
                    state_next = wdl_pkg::WDL_IDLE;
                end
            end
            default:
            begin
                state_next = wdl_pkg::WDL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            state_reg <= wdl_pkg::WDL_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // holding register and bit count
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            hold_reg    <= wdl_pkg::CODE_RST;
            bit_cnt_reg <= wdl_pkg::BIT_TOP;
        end
        else if (take_word)
        begin
            hold_reg    <= host_req_in.word;
            bit_cnt_reg <= wdl_pkg::BIT_TOP;
        end
        else if (state_reg == wdl_pkg::WDL_SHIFT)
        begin
            hold_reg    <= {hold_reg[wdl_pkg::WORD_W-2:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg - 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // channel multiplexer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            chan_reg <= wdl_pkg::FIRST_CH;
        end
        else if (take_update)
        begin
            chan_reg <= wdl_pkg::FIRST_CH;
        end
        else if (chan_step)
        begin
            chan_reg <= next_chan(chan_reg);
        end
    end

    // ----------------------------------------------------------------
    // channel shift registers
    // ----------------------------------------------------------------
    // the shift reaches the addressed entry alone, the rest hold
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            for (int i = 0; i < wdl_pkg::CH_COUNT; i++)
            begin
                stage_mem[i] <= wdl_pkg::CODE_RST;
            end
        end
        else if (state_reg == wdl_pkg::WDL_SHIFT)
        begin
            stage_mem[chan_reg] <= {stage_mem[chan_reg][wdl_pkg::WORD_W-2:0],
                                    hold_reg[wdl_pkg::WORD_W-1]};
        end
    end

    // ----------------------------------------------------------------
    // converter latches
    // ----------------------------------------------------------------
    // all 256 codes change on one edge to keep the weight glitch short
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            dac_code_out <= '0;
        end
        else if (take_update)
        begin
            for (int i = 0; i < wdl_pkg::CH_COUNT; i++)
            begin
                dac_code_out[i] <= stage_mem[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // settle indication
    // ----------------------------------------------------------------
    // converters need time after an update; host polls this
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            settle_cnt_reg <= '0;
            settling_out   <= 1'b0;
        end
        else if (take_update)
        begin
            settle_cnt_reg <= wdl_pkg::SETTLE_W'(wdl_pkg::SETTLE_CYCLES);
            settling_out   <= 1'b1;
        end
        else if (settle_cnt_reg != '0)
        begin
            settle_cnt_reg <= settle_cnt_reg - 1'b1;
            settling_out   <= (settle_cnt_reg != wdl_pkg::SETTLE_W'(1));
        end
    end

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            ready_out      <= 1'b1;
            all_loaded_out <= 1'b0;
            channel_out    <= wdl_pkg::FIRST_CH;
        end
        else
        begin
            ready_out      <= (state_next == wdl_pkg::WDL_IDLE);
            all_loaded_out <= (state_next == wdl_pkg::WDL_FULL);
            if (take_update)
            begin
                channel_out <= wdl_pkg::FIRST_CH;
            end
            else if (chan_step)
            begin
                channel_out <= next_chan(chan_reg);
            end
        end
    end

endmodule : wdl_loader

// ===== hdl/wdl_pkg.sv
package wdl_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int WORD_W    = 8;
    localparam int CH_COUNT  = 256;
    localparam int CH_W      = $clog2(CH_COUNT);
    localparam int BIT_CNT_W = $clog2(WORD_W);

    localparam logic [CH_W-1:0]      FIRST_CH = 8'h00;
    localparam logic [CH_W-1:0]      LAST_CH  = 8'hFF;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_TOP  = 3'h7;
    localparam logic [WORD_W-1:0]    CODE_RST = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 25;
    localparam int SETTLE_TIME_US = 10;
    // least time, so round up
    localparam int SETTLE_CYCLES  =
        (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W       = $clog2(SETTLE_CYCLES + 1);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        WDL_IDLE  = 3'b001,
        WDL_SHIFT = 3'b010,
        WDL_FULL  = 3'b100
    } wdl_state_type;

    typedef struct packed
    {
        logic              load;
        logic [WORD_W-1:0] word;
        logic              update;
    } wdl_host_req_type;

    typedef logic [CH_COUNT-1:0][WORD_W-1:0] wdl_codes_type;

endpackage : wdl_pkg

// ===== verif/wdl_loader_sva.sv
`timescale 1ns/1ps
module wdl_loader_sva
(
    input wire logic                      sys_clk_in,
    input wire logic                      rstn_in,
    input wire wdl_pkg::wdl_host_req_type host_req_in,
    input wire logic                      ready_out,
    input wire logic                      all_loaded_out,
    input wire logic [wdl_pkg::CH_W-1:0]  channel_out,
    input wire logic                      settling_out,
    input wire wdl_pkg::wdl_codes_type    dac_code_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);
    logic        take;
    logic        upd_ok;
    logic [15:0] settle_reg;
    assign take = ready_out && host_req_in.load && !host_req_in.update;
    assign upd_ok = host_req_in.update && (ready_out || all_loaded_out);
    // restarts on every accepted update (ready or all loaded), so a second update mid-settle is judged alone
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in || upd_ok)
            settle_reg <= 16'h0000;
        else if (settling_out)
            settle_reg <= settle_reg + 16'h0001;
    end
    sequence busy_s;
        !ready_out [*8];
    endsequence
    sequence back_s;
        ready_out || all_loaded_out;
    endsequence
    a_shift_eight: assert property (take |=> busy_s ##1 back_s)
        else $error("busy span wrong");
    a_chan_step: assert property ($rose(ready_out) && !$past(upd_ok)
        |-> channel_out == $past(channel_out) + 8'h01) else $error("channel step");
    a_upd_effect: assert property (upd_ok |=> channel_out == wdl_pkg::FIRST_CH
        && settling_out && ready_out && !all_loaded_out) else $error("update effect");
    a_codes_hold: assert property (!upd_ok |=> $stable(dac_code_out))
        else $error("codes moved");
    a_full_hold: assert property (all_loaded_out && !host_req_in.update
        |=> all_loaded_out && !ready_out && $stable(channel_out)) else $error("full left");
    a_settle_len: assert property ($fell(settling_out)
        |-> settle_reg == wdl_pkg::SETTLE_CYCLES) else $error("settle length");
    a_settle_cause: assert property ($rose(settling_out) |-> $past(upd_ok))
        else $error("settle without update");
    a_last_fill: assert property (take && channel_out == wdl_pkg::LAST_CH
        |-> ##9 all_loaded_out && !ready_out) else $error("last channel");
endmodule : wdl_loader_sva

bind wdl_loader wdl_loader_sva u_wdl_loader_sva
(
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .host_req_in(host_req_in),
    .ready_out(ready_out), .all_loaded_out(all_loaded_out), .channel_out(channel_out),
    .settling_out(settling_out), .dac_code_out(dac_code_out)
);

// ===== verif/wdl_host_model.sv
`timescale 1ns/1ps
module wdl_host_model
(
    input  wire logic                   sys_clk_in,
    input  wire logic                   rstn_in,
    input  wire logic                   ready_in,
    input  wire logic                   full_in,
    input  wire logic                   settle_in,
    input  wire logic                   run_in,
    input  wire logic                   upd_in,
    input  wire wdl_pkg::wdl_codes_type words_in,
    output wdl_pkg::wdl_host_req_type   host_req_out,
    output logic [8:0]                  idx_out
);
    // new words only once the converters have settled
    assign host_req_out.load = run_in && ready_in && !settle_in && !upd_in;
    // an idle bus shows the inverse, so a stale word never passes for a fresh one
    assign host_req_out.word = host_req_out.load ? words_in[idx_out[7:0]]
                                                 : ~words_in[idx_out[7:0]];
    assign host_req_out.update = upd_in;
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in || (upd_in && (ready_in || full_in)))
            idx_out <= 9'h000;
        else if (host_req_out.load)
            idx_out <= idx_out + 9'h001;
    end
endmodule : wdl_host_model

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic                      sys_clk_in = 1'b0;
    logic                      rstn_in = 1'b0;
    logic                      run, upd, ready, all_loaded, settling;
    logic [wdl_pkg::CH_W-1:0]  channel;
    logic [8:0]                idx;
    logic [31:0]               seed = 32'h49AE68A3;
    wdl_pkg::wdl_host_req_type host_req;
    wdl_pkg::wdl_codes_type    words, exp_codes, dac_code;
    int                        bad_count = 0;
    int                        check_count = 0;
    always #12.5 sys_clk_in = ~sys_clk_in;
    wdl_loader u_wdl_loader (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .host_req_in(host_req), .ready_out(ready), .all_loaded_out(all_loaded),
        .channel_out(channel), .settling_out(settling), .dac_code_out(dac_code));
    wdl_host_model u_wdl_host_model (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .ready_in(ready), .full_in(all_loaded), .settle_in(settling), .run_in(run),
        .upd_in(upd), .words_in(words), .host_req_out(host_req), .idx_out(idx));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic tick();
        @(posedge sys_clk_in);
        #1;
    endtask : tick
    // loads k channels; mid puts an update into the first shift, which must be ignored
    task automatic load_n(input int k, input bit mid);
        int n;
        for (int i = 0; i < 256; i++)
        begin
            seed = xs(seed);
            words[i] = seed[7:0];
        end
        run = 1'b1;
        n = 0;
        while (ready && mid && n < 50)
        begin
            tick();
            n++;
        end
        upd = mid;
        tick();
        upd = 1'b0;
        n = 0;
        while (idx != k && n < 3000)
        begin
            tick();
            n++;
        end
        run = 1'b0;
        repeat (9) tick();
        chk(all_loaded === (k == 256) && ready === (k != 256), "full flag");
        if (k < 256)
            chk(channel === k[7:0], "channel count");
        chk(dac_code === exp_codes, "codes before update");
        for (int i = 0; i < k; i++)
            exp_codes[i] = words[i];
    endtask : load_n
    task automatic do_update();
        int n;
        upd = 1'b1;
        tick();
        upd = 1'b0;
        chk(dac_code === exp_codes, "codes after update");
        chk(channel === wdl_pkg::FIRST_CH && settling === 1'b1, "update state");
        n = 0;
        while (settling === 1'b1 && n < 600)
        begin
            tick();
            n++;
        end
        chk(n == wdl_pkg::SETTLE_CYCLES, "settle span");
    endtask : do_update
    initial
    begin
        run = 1'b0;
        upd = 1'b0;
        words = '0;
        exp_codes = '0;
        repeat (6) @(posedge sys_clk_in);
        #1 rstn_in = 1'b1;
        chk(ready === 1'b1 && channel === wdl_pkg::FIRST_CH && dac_code === exp_codes
            && all_loaded === 1'b0 && settling === 1'b0, "reset state");
        load_n(256, 1'b1);
        do_update();
        load_n(1, 1'b0);
        do_update();
        load_n(255, 1'b0);
        do_update();
        seed = xs(seed);
        load_n(2 + int'(seed[5:0]), 1'b0);
        do_update();
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        bad_count++;
        print_verdict();
    end
endmodule : tb
